/* File: rtl/dual_port_gpio_with_wake.sv */
// Two 8-bit I/O ports with input gating, wake-up and pin interrupts
`timescale 1ns/1ps
`default_nettype none

// Function
// - Upper port B pin pair input enable, reset on
// - Middle port B pins input enable, reset on
// - Port B pin5 enable gates input, wake, interrupt
// - Port B pin0 enable gates input, wake, interrupt
// - Disabled port B pin never wakes system
// - Input enable register is write-only, reads zero
// - Port A data register, reset zero
// - Port A direction register, one means output
// - Port A pin5 drives low or floats
// - Port A pull-up only on input pins
// - Port B data register, reset zero
// - Port B direction register, one means output
// - Port B pull-up only on input pins
// - Pin pairs set sticky interrupt bits 0, 1
// - Two-bit edge code per pin pair
module dual_port_gpio_with_wake
  import gpio_pkg::*;
#(
  parameter int ADDR_W = 8 // Wishbone byte address width
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [7:0] pa_pin_in,
  output logic [7:0] pa_pin_out,
  output logic [7:0] pa_pin_oe_out,
  output logic [7:0] pa_pullup_out,
  input wire logic [7:0] pb_pin_in,
  output logic [7:0] pb_pin_out,
  output logic [7:0] pb_pin_oe_out,
  output logic [7:0] pb_pullup_out,
  output logic wake_out,
  output logic irq_out
);

  // Refuse address widths that cannot reach the highest word
  if (ADDR_W < IDX_W + 2) begin : g_bad_addr
    $error("ADDR_W too small for register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge match for one pin under its pair's two-bit code
  function automatic logic edge_hit(input logic [1:0] code, input logic rise,
                                    input logic fall);
    case (code)
      EDGE_BOTH: edge_hit = rise | fall;
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      default: edge_hit = 1'b0; // Reserved code raises nothing
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] pa_data; // Port A output latch
  logic [7:0] pa_dir; // Port A direction, 1 is output
  logic [7:0] pa_pull; // Port A pull-up enables
  logic [7:0] pb_data; // Port B output latch
  logic [7:0] pb_dir; // Port B direction
  logic [7:0] pb_pull; // Port B pull-up enables
  logic [7:0] pb_inen; // Port B digital input enables
  logic [3:0] edge_sel; // Two edge codes, one per pin pair
  logic [1:0] int_stat; // Sticky interrupt requests
  logic [1:0] int_mask; // Interrupt enables

  // Bus decode
  logic [IDX_W-1:0] word_idx; // Word index of the access
  logic bus_req; // Request present
  logic wr_fire; // Write takes effect at this edge
  logic [7:0] wr_byte; // Low byte of write data
  logic [31:0] next_rdata; // Read mux result

  assign word_idx = wb_adr_in[IDX_W+1:2];
  assign bus_req = wb_cyc_in & wb_stb_in;
  // Write lands at the edge where the master sees ack
  assign wr_fire = bus_req & wb_we_in & wb_ack_out & wb_sel_in[0];
  assign wr_byte = wb_dat_in[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers; first stage feeds only the second
  logic [7:0] pa_meta; // Port A first stage
  logic [7:0] pa_sync; // Port A second stage
  logic [7:0] pb_meta; // Port B first stage
  logic [7:0] pb_sync; // Port B second stage
  logic [7:0] pa_prev; // Port A level one cycle earlier
  logic [7:0] pb_prev; // Port B gated level one cycle earlier
  logic [7:0] pb_en_prev; // Port B enables one cycle earlier
  logic [7:0] pb_gated; // Port B level seen by logic
  logic [7:0] pb_change; // Port B edges on enabled pins

  // Two flops per pin, no reset needed on data path but kept defined
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pa_meta <= RST_PORT;
      pa_sync <= RST_PORT;
      pb_meta <= RST_PORT;
      pb_sync <= RST_PORT;
    end else begin
      pa_meta <= pa_pin_in;
      pa_sync <= pa_meta;
      pb_meta <= pb_pin_in;
      pb_sync <= pb_meta;
    end
  end

  // Disabled port B input pins read as zero
  assign pb_gated = pb_sync & pb_inen;
  // An edge counts only if the pin was enabled in both cycles, so that
  // turning an enable on or off never fakes a toggle
  assign pb_change = (pb_gated ^ pb_prev) & pb_inen & pb_en_prev;

  // History for edge detection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pa_prev <= RST_PORT;
      pb_prev <= RST_PORT;
      pb_en_prev <= RST_PB_INEN;
    end else begin
      pa_prev <= pa_sync;
      pb_prev <= pb_gated;
      pb_en_prev <= pb_inen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pair edges
  logic pa0_rise, pa0_fall, pa4_rise, pa4_fall; // Port A pair pins
  logic pb5_rise, pb5_fall, pb0_rise, pb0_fall; // Port B pair pins
  logic [1:0] pair_event; // Raw pair events

  assign pa0_rise = pa_sync[PA_PIN0] & ~pa_prev[PA_PIN0];
  assign pa0_fall = ~pa_sync[PA_PIN0] & pa_prev[PA_PIN0];
  assign pa4_rise = pa_sync[PA_PIN4] & ~pa_prev[PA_PIN4];
  assign pa4_fall = ~pa_sync[PA_PIN4] & pa_prev[PA_PIN4];
  assign pb5_rise = pb_change[PB_PIN5] & pb_gated[PB_PIN5];
  assign pb5_fall = pb_change[PB_PIN5] & ~pb_gated[PB_PIN5];
  assign pb0_rise = pb_change[PB_PIN0] & pb_gated[PB_PIN0];
  assign pb0_fall = pb_change[PB_PIN0] & ~pb_gated[PB_PIN0];

  // Either pin of a pair raises that pair's request
  assign pair_event[INT_PAIR0] =
    edge_hit(edge_sel[EDGE_PAIR0_LSB +: 2], pa0_rise, pa0_fall) |
    edge_hit(edge_sel[EDGE_PAIR0_LSB +: 2], pb5_rise, pb5_fall);
  assign pair_event[INT_PAIR1] =
    edge_hit(edge_sel[EDGE_PAIR1_LSB +: 2], pb0_rise, pb0_fall) |
    edge_hit(edge_sel[EDGE_PAIR1_LSB +: 2], pa4_rise, pa4_fall);

  ////////////////////////////////////////////////////////////////////////////
  // Port A registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pa_data <= RST_PORT;
      pa_dir <= RST_PORT;
      pa_pull <= RST_PORT;
    end else if (wr_fire) begin
      case (word_idx)
        IDX_PA_DATA: pa_data <= wr_byte;
        IDX_PA_DIR: pa_dir <= wr_byte;
        IDX_PA_PULL: pa_pull <= wr_byte;
        default: ; // Other words belong elsewhere
      endcase
    end
  end

  // Port B registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pb_data <= RST_PORT;
      pb_dir <= RST_PORT;
      pb_pull <= RST_PORT;
      pb_inen <= RST_PB_INEN;
    end else if (wr_fire) begin
      case (word_idx)
        IDX_PB_DATA: pb_data <= wr_byte;
        IDX_PB_DIR: pb_dir <= wr_byte;
        IDX_PB_PULL: pb_pull <= wr_byte;
        IDX_PB_INEN: pb_inen <= wr_byte;
        default: ;
      endcase
    end
  end

  // Interrupt configuration
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      edge_sel <= RST_EDGE_SEL;
      int_mask <= RST_INT;
    end else if (wr_fire) begin
      case (word_idx)
        IDX_EDGE_SEL: edge_sel <= wr_byte[3:0];
        IDX_INT_MASK: int_mask <= wr_byte[1:0];
        default: ;
      endcase
    end
  end

  // Sticky requests; write one clears, a new event wins over the clear
  logic [1:0] clr_bits; // Bits software clears this edge
  assign clr_bits = (wr_fire && word_idx == IDX_INT_STAT) ? wr_byte[1:0] : RST_INT;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      int_stat <= RST_INT;
    end else begin
      int_stat <= (int_stat & ~clr_bits) | pair_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; data words mix pin level and latch by direction
  always_comb begin
    next_rdata = ZERO_WORD;
    case (word_idx)
      IDX_PA_DATA: next_rdata[7:0] = (pa_dir & pa_data) | (~pa_dir & pa_sync);
      IDX_PA_DIR: next_rdata[7:0] = pa_dir;
      IDX_PA_PULL: next_rdata[7:0] = pa_pull;
      IDX_PB_DATA: next_rdata[7:0] = (pb_dir & pb_data) | (~pb_dir & pb_gated);
      IDX_PB_DIR: next_rdata[7:0] = pb_dir;
      IDX_PB_PULL: next_rdata[7:0] = pb_pull;
      IDX_PB_INEN: next_rdata = ZERO_WORD;
      IDX_EDGE_SEL: next_rdata[3:0] = edge_sel;
      IDX_INT_STAT: next_rdata[1:0] = int_stat;
      IDX_INT_MASK: next_rdata[1:0] = int_mask;
      default: next_rdata = ZERO_WORD; // Unmapped reads zero
    endcase
  end

  // Classic slave: one wait state, ack for one cycle, then drop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= ZERO_WORD;
    end else begin
      wb_ack_out <= bus_req & ~wb_ack_out;
      if (bus_req && !wb_ack_out) begin
        wb_dat_out <= wb_we_in ? ZERO_WORD : next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered; they follow the registers by one cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pa_pin_out <= RST_PORT;
      pa_pin_oe_out <= RST_PORT;
      pa_pullup_out <= RST_PORT;
      pb_pin_out <= RST_PORT;
      pb_pin_oe_out <= RST_PORT;
      pb_pullup_out <= RST_PORT;
    end else begin
      pa_pin_out <= pa_data;
      pa_pin_oe_out <= pa_dir;
      // Low-only pin floats instead of driving high
      pa_pin_oe_out[PA_LOW_ONLY] <= pa_dir[PA_LOW_ONLY] & ~pa_data[PA_LOW_ONLY];
      pa_pin_out[PA_LOW_ONLY] <= 1'b0;
      pa_pullup_out <= pa_pull & ~pa_dir;
      pb_pin_out <= pb_data;
      pb_pin_oe_out <= pb_dir;
      pb_pullup_out <= pb_pull & ~pb_dir;
    end
  end

  // Wake pulse on any toggle of an enabled pin
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= (|(pa_sync ^ pa_prev)) | (|pb_change);
    end
  end

  // Level interrupt while an unmasked request stands
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(int_stat & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_pb_gate_zero: assert property (
    ##1 (pb_inen[PB_PIN5] == 1'b0) |-> (pb_change[PB_PIN5] == 1'b0 && !pb_gated[PB_PIN5]))
    else $error("disabled pin5 gave level or edge");
  a_pa5_no_high: assert property (
    pa_pin_oe_out[PA_LOW_ONLY] |-> !pa_pin_out[PA_LOW_ONLY])
    else $error("low-only pin driven high");
  a_pa5_float: assert property (
    (pa_dir[PA_LOW_ONLY] && pa_data[PA_LOW_ONLY]) |=> !pa_pin_oe_out[PA_LOW_ONLY])
    else $error("low-only pin not floating on data one");
  a_pullup_input: assert property (
    ##1 (pa_pullup_out & $past(pa_dir)) == 8'h00)
    else $error("port A pull-up on output pin");
  a_pb_pull_in: assert property (
    ##1 (pb_pullup_out & $past(pb_dir)) == 8'h00)
    else $error("port B pull-up on output pin");
  a_inen_reads_0: assert property (
    (bus_req && !wb_ack_out && word_idx == IDX_PB_INEN) |=> wb_dat_out == ZERO_WORD)
    else $error("input enable register read back");
  a_stat_sticky: assert property (
    (int_stat[INT_PAIR0] && !clr_bits[INT_PAIR0]) |=> int_stat[INT_PAIR0])
    else $error("request bit lost without clear");
  a_pair1_sets: assert property (
    pair_event[INT_PAIR1] |=> int_stat[INT_PAIR1])
    else $error("pair1 event not recorded");
  a_rise_only: assert property (
    (edge_sel[EDGE_PAIR1_LSB +: 2] == EDGE_RISE && pa4_fall && !pb0_rise && !pa4_rise)
      |-> !pair_event[INT_PAIR1])
    else $error("falling edge raised rise-only pair");
  a_sync_delay: assert property (
    ##3 pa_sync == $past(pa_pin_in, 2))
    else $error("synchroniser depth wrong");
  a_rd_latch: assert property (
    (bus_req && !wb_ack_out && !wb_we_in && word_idx == IDX_PB_DATA && pb_dir == 8'hFF)
      |=> wb_dat_out[7:0] == $past(pb_data))
    else $error("output pin read not latch");
  a_wake_gated: assert property (
    (pa_sync == pa_prev && pb_change == 8'h00) |=> !wake_out)
    else $error("wake without enabled toggle");
  a_ack_once: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer, request bits and registered pin drivers
  // Fixed one wait state; a master that holds its request sees ack again every second cycle
  a_ack_after_req: assert property (
    (bus_req && !wb_ack_out) |=> wb_ack_out)
    else $error("request not answered after one wait state");
  a_pair0_sets: assert property (
    pair_event[INT_PAIR0] |=> int_stat[INT_PAIR0])
    else $error("pair0 event not recorded");
  a_stat_clear: assert property (
    (clr_bits[INT_PAIR0] && !pair_event[INT_PAIR0]) |=> !int_stat[INT_PAIR0])
    else $error("request bit survived its clear");
  // Level output tracks unmasked requests one cycle late
  a_irq_level: assert property (
    ##1 irq_out == $past(|(int_stat & int_mask)))
    else $error("interrupt level does not follow requests");
  a_wake_follows: assert property (
    (|pb_change) |=> wake_out)
    else $error("enabled toggle gave no wake");
  a_pb_oe_dir: assert property (
    ##1 pb_pin_oe_out == $past(pb_dir))
    else $error("port B enable not from direction");
  a_pb_out_data: assert property (
    ##1 pb_pin_out == $past(pb_data))
    else $error("port B drive not from data latch");

  c_pair0_irq: cover property (pair_event[INT_PAIR0] ##1 int_stat[INT_PAIR0] ##1 irq_out);
  c_set_vs_clr: cover property (pair_event[INT_PAIR1] && clr_bits[INT_PAIR1]);
  c_wake: cover property (wake_out);
  c_pa5_float: cover property (pa_dir[PA_LOW_ONLY] && pa_data[PA_LOW_ONLY]);
  // Software polling the request word
  c_rd_stat: cover property (bus_req && !wb_we_in && word_idx == IDX_INT_STAT);

endmodule

`default_nettype wire

/* File: rtl/gpio_pkg.sv */
// Constants for the dual port general purpose I/O block
package gpio_pkg;
  localparam int PORT_W = 8; // Pins per port
  localparam int IDX_W = 6; // Word index width
  // Word indices; byte address is four times the index
  localparam logic [5:0] IDX_PB_INEN = 6'h0E;
  localparam logic [5:0] IDX_PA_DATA = 6'h10;
  localparam logic [5:0] IDX_PA_DIR = 6'h11;
  localparam logic [5:0] IDX_PA_PULL = 6'h12;
  localparam logic [5:0] IDX_PB_DATA = 6'h14;
  localparam logic [5:0] IDX_PB_DIR = 6'h15;
  localparam logic [5:0] IDX_PB_PULL = 6'h16;
  localparam logic [5:0] IDX_EDGE_SEL = 6'h18;
  localparam logic [5:0] IDX_INT_STAT = 6'h19;
  localparam logic [5:0] IDX_INT_MASK = 6'h1A;
  // Reset values
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [7:0] RST_PB_INEN = 8'hFF;
  localparam logic [3:0] RST_EDGE_SEL = 4'h0;
  localparam logic [1:0] RST_INT = 2'h0;
  // Edge select codes
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  // Pin positions
  localparam int PA_LOW_ONLY = 5;
  localparam int PA_PIN0 = 0;
  localparam int PA_PIN4 = 4;
  localparam int PB_PIN0 = 0;
  localparam int PB_PIN5 = 5;
  // Field positions in the edge select and interrupt registers
  localparam int EDGE_PAIR0_LSB = 0;
  localparam int EDGE_PAIR1_LSB = 2;
  localparam int INT_PAIR0 = 0;
  localparam int INT_PAIR1 = 1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

/* File: bench/pin_board.sv */
// Board model: block drivers, outside sources and pull-ups on one port
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic clk_in, // Model clock
  input wire logic [7:0] drv_in, // Value the block drives
  input wire logic [7:0] oe_in, // Block drives pin when high
  input wire logic [7:0] pull_in, // Pull-up switched on
  input wire logic [7:0] ext_en_in, // Outside source present
  input wire logic [7:0] ext_val_in, // Level of outside source
  output logic [7:0] level_out // Resolved pin level
);
  ////////////////////////////////////////////////////////////
  // Block wins, then outside source, then pull-up; a bare floating
  // pin toggles every cycle so no stale level can pass by luck
  initial level_out = 8'h00;
  always @(posedge clk_in) begin
    level_out <= (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in)
      | (~oe_in & ~ext_en_in & (pull_in | ~level_out));
  end
endmodule
`default_nettype wire

/* File: bench/dual_port_gpio_with_wake_tb_top.sv */
// Self-checking bench for the dual port I/O block
`timescale 1ns/1ps
`default_nettype none
module dual_port_gpio_with_wake_tb_top;
  import gpio_pkg::*;
  logic clk_in = 1'b0; // System clock
  logic rst_in = 1'b1; // Reset, high at start
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
  logic [7:0] adr = 8'h00; // Byte address
  logic [3:0] sel = 4'h0; // Byte enables
  logic [31:0] wdat = 32'h0, rdat, dat_o; // Bus data
  logic ack, wake, irq; // Block status outputs
  logic [7:0] pa_i, pa_o, pa_oe, pa_pu, pb_i, pb_o, pb_oe, pb_pu; // Pins
  logic [7:0] pa_x = 8'h00, pb_x = 8'h00, pa_xe = 8'hFF, pb_xe = 8'hFF; // Outside drive
  int errors = 0, samples_checked = 0, cycles = 0, wakes = 0;
  always #5 clk_in = ~clk_in;
  dual_port_gpio_with_wake dut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(dat_o), .wb_ack_out(ack), .pa_pin_in(pa_i), .pa_pin_out(pa_o),
    .pa_pin_oe_out(pa_oe), .pa_pullup_out(pa_pu), .pb_pin_in(pb_i), .pb_pin_out(pb_o),
    .pb_pin_oe_out(pb_oe), .pb_pullup_out(pb_pu), .wake_out(wake), .irq_out(irq));
  pin_board board_a (.clk_in(clk_in), .drv_in(pa_o), .oe_in(pa_oe), .pull_in(pa_pu),
    .ext_en_in(pa_xe), .ext_val_in(pa_x), .level_out(pa_i));
  pin_board board_b (.clk_in(clk_in), .drv_in(pb_o), .oe_in(pb_oe), .pull_in(pb_pu),
    .ext_en_in(pb_xe), .ext_val_in(pb_x), .level_out(pb_i));
  ////////////////////////////////////////////////////////////
  // Wake pulse counter and hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (wake === 1'b1) wakes++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; waits for ack, only the cycle guard ends a hang
  task automatic bus(input logic w, input logic [5:0] ix, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d, 4'hF);
  endtask
  // Read and compare the bits in m; upper bits must be zero
  task automatic rd(input string nm, input logic [5:0] ix, input logic [7:0] e,
                    input logic [7:0] m);
    bus(1'b0, ix, 8'h00, 4'hF);
    chk(nm, e & m, rdat[7:0] & m);
    chk("upper", 8'h00, {7'h0, |rdat[31:8]});
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Input level seen inside: outside source, else pull-up, gated by enable
  function automatic logic [7:0] lvl(input logic [7:0] xe, x, pu, en);
    return ((xe & x) | (~xe & pu)) & en;
  endfunction
  // Output pins read latch, input pins read level
  function automatic logic [7:0] mix(input logic [7:0] dir, d, l);
    return (dir & d) | (~dir & l);
  endfunction
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [5:0] ixs [10];
    logic [7:0] ad, ap, at, bd, bp, bt, en, ax, axe, bx, bxe;
    logic [1:0] mk, st;
    int w0;
    ixs = '{IDX_PB_INEN, IDX_PA_DATA, IDX_PA_DIR, IDX_PA_PULL, IDX_PB_DATA, IDX_PB_DIR,
            IDX_PB_PULL, IDX_EDGE_SEL, IDX_INT_STAT, IDX_INT_MASK};
    void'($urandom(97));
    pause(8);
    rst_in <= 1'b0;
    // Reset values, pins held low outside
    foreach (ixs[k]) rd("reset", ixs[k], 8'h00, 8'hFF);
    chk("oe_reset", 8'h00, pa_oe | pb_oe);
    // Unmapped place and a write without byte lane 0 are ignored
    wr(6'h1F, 8'hFF);
    rd("unmapped", 6'h1F, 8'h00, 8'hFF);
    bus(1'b1, IDX_PA_DIR, 8'hFF, 4'hE);
    rd("sel_off", IDX_PA_DIR, 8'h00, 8'hFF);
    // Random port setups, first two as corners
    for (int i = 0; i < 24; i++) begin
      {ad, ap, at, bd, bp, bt} = {$urandom, $urandom};
      {en, ax, axe, bx, bxe} = {$urandom, $urandom};
      if (i == 0) {ad, at, ap} = 24'hFFFFFF;
      if (i == 1) {en, bd} = 16'h0000;
      pa_x <= ax;
      pa_xe <= axe;
      pb_x <= bx;
      pb_xe <= bxe;
      wr(IDX_PA_DATA, at);
      wr(IDX_PA_DIR, ad);
      wr(IDX_PA_PULL, ap);
      wr(IDX_PB_DATA, bt);
      wr(IDX_PB_DIR, bd);
      wr(IDX_PB_PULL, bp);
      wr(IDX_PB_INEN, en);
      pause(6);
      chk("pa_oe", ad & ~(at & 8'h20), pa_oe);
      chk("pa_out", at & ad & 8'hDF, pa_o & pa_oe);
      chk("pa_pull", ap & ~ad, pa_pu);
      chk("pb_oe", bd, pb_oe);
      chk("pb_out", bt & bd, pb_o & pb_oe);
      chk("pb_pull", bp & ~bd, pb_pu);
      rd("pa_data", IDX_PA_DATA, mix(ad, at, lvl(axe, ax, ap, 8'hFF)), ad | axe | ap);
      rd("pb_data", IDX_PB_DATA, mix(bd, bt, lvl(bxe, bx, bp, en)), bd | bxe | bp | ~en);
      rd("pa_dir", IDX_PA_DIR, ad, 8'hFF);
      rd("pb_pull_reg", IDX_PB_PULL, bp, 8'hFF);
      rd("pb_inen", IDX_PB_INEN, 8'h00, 8'hFF);
    end
    // Pin interrupts: every edge code, both directions, both pairs
    wr(IDX_PA_DIR, 8'h00);
    wr(IDX_PB_DIR, 8'h00);
    wr(IDX_PB_INEN, 8'hFF);
    {pa_x, pb_x, pa_xe, pb_xe} <= 32'h0000FFFF;
    pause(8);
    for (int c = 0; c < 4; c++) begin
      mk = (c == 0) ? 2'h3 : 2'($urandom);
      wr(IDX_EDGE_SEL, {4'h0, 2'(c), 2'(c)});
      wr(IDX_INT_MASK, {6'h0, mk});
      wr(IDX_INT_STAT, 8'h03);
      for (int ph = 0; ph < 2; ph++) begin
        w0 = wakes;
        pa_x[PA_PIN0] <= (ph == 0);
        pb_x[PB_PIN0] <= (ph == 0);
        pause(8);
        st = (c == 0 || c == ph + 1) ? 2'h3 : 2'h0;
        rd("int_status", IDX_INT_STAT, {6'h0, st}, 8'hFF);
        chk("irq", {7'h0, |(st & mk)}, {7'h0, irq});
        chk("wake", 8'h01, 8'(wakes - w0));
        wr(IDX_INT_STAT, 8'h03);
        pause(2);
        chk("irq_clear", 8'h00, {7'h0, irq});
      end
    end
    // Disabled pins: no request, no wake
    wr(IDX_EDGE_SEL, 8'h00);
    wr(IDX_PB_INEN, 8'hDE);
    pause(3);
    w0 = wakes;
    pb_x <= 8'h21;
    pause(8);
    rd("off_status", IDX_INT_STAT, 8'h00, 8'hFF);
    chk("off_wake", 8'h00, 8'(wakes - w0));
    // Re-enabled: pin 5 of port B and pin 4 of port A raise both pairs
    wr(IDX_PB_INEN, 8'hFF);
    pause(4);
    wr(IDX_INT_STAT, 8'h03);
    pb_x <= 8'h01;
    pa_x[PA_PIN4] <= 1'b1;
    pause(8);
    rd("pair_alt", IDX_INT_STAT, 8'h03, 8'hFF);
    report_and_stop();
  end
endmodule
`default_nettype wire
